// ---- aor_output_bank.sv ----
// Purpose: Read-only output register bank with auto-increment sequencing.
// Assumes: The serial port front end presents a start address and read strobes.
// Notes:   Read data and the running address come straight from flip-flops.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] The temperature byte reads at 0x01 and is skipped by auto-increment when its inclusion setting is clear.
// [R2] The 12-bit magnitude reads as two bytes at 0x02 and 0x03.
// [R3] Both magnitude bytes are skipped by auto-increment while magnitude calculation is disabled.
// [R4] Byte order 0 gives bits 7..0 low and 11..8 high; byte order 1 gives bits 11..4 low and 3..0 high.
// [R5] X, Y and Z samples read at 0x04/0x05, 0x06/0x07 and 0x08/0x09 in the selected byte order.
// [R6] A disabled X axis removes both X bytes from the auto-increment sequence.
// [R7] A disabled Y axis removes both Y bytes from the auto-increment sequence.
// [R8] A disabled Z axis removes both Z bytes from the auto-increment sequence.
// [R9] In normal read mode the address after 0x09 wraps to 0x00 rather than 0x0A.
// [R10] Address 0x00 reports the event flags as a read-only register.
// [R11] Address 0x0A is factory reserved and reads 0x00.
// [R12] In fast read mode auto-increment skips the magnitude high byte, steps by two from 0x04 and wraps to 0x00 after Z.
module aor_output_bank (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        addr_load,
    input  wire logic [7:0]  addr_in,
    input  wire logic        read_strobe,
    input  wire logic [7:0]  event_flags_in,
    input  wire logic [7:0]  temperature_in,
    input  wire logic [11:0] accel_norm_value,
    input  wire logic [11:0] x_sample,
    input  wire logic [11:0] y_sample,
    input  wire logic [11:0] z_sample,
    input  wire logic        byte_order_select,
    input  wire logic        fast_read,
    input  wire logic        temperature_autoinc_include,
    input  wire logic        magnitude_calc_enable,
    input  wire logic        x_axis_disable,
    input  wire logic        y_axis_disable,
    input  wire logic        z_axis_disable,
    output logic      [7:0]  read_data,
    output logic             read_valid,
    output logic      [7:0]  current_addr
);
    localparam int SB = aor_pkg::SAMPLE_BITS;

    // ==========================================================
    // Byte splitting
    // ==========================================================
    logic [7:0] mag_low;
    logic [7:0] mag_high;
    logic [7:0] x_low;
    logic [7:0] x_high;
    logic [7:0] y_low;
    logic [7:0] y_high;
    logic [7:0] z_low;
    logic [7:0] z_high;
    logic [7:0] next_addr;
    logic [7:0] sel_data;

    aor_byte_split u_mag (
        .value             (accel_norm_value[SB-1:0]),
        .byte_order_select (byte_order_select),
        .low_byte          (mag_low),
        .high_byte         (mag_high)
    ); // [R2]
    aor_byte_split u_x (
        .value             (x_sample),
        .byte_order_select (byte_order_select),
        .low_byte          (x_low),
        .high_byte         (x_high)
    ); // [R5]
    aor_byte_split u_y (
        .value             (y_sample),
        .byte_order_select (byte_order_select),
        .low_byte          (y_low),
        .high_byte         (y_high)
    ); // [R5]
    aor_byte_split u_z (
        .value             (z_sample),
        .byte_order_select (byte_order_select),
        .low_byte          (z_low),
        .high_byte         (z_high)
    ); // [R5]

    // ==========================================================
    // Address sequencing
    // ==========================================================
    aor_next_addr u_seq (
        .addr                        (current_addr),
        .fast_read                   (fast_read),
        .temperature_autoinc_include (temperature_autoinc_include),
        .magnitude_calc_enable       (magnitude_calc_enable),
        .x_axis_disable              (x_axis_disable),
        .y_axis_disable              (y_axis_disable),
        .z_axis_disable              (z_axis_disable),
        .next_addr                   (next_addr)
    );

    // A load takes priority over a read in the same cycle.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            current_addr <= aor_pkg::ADDR_EVENT_FLAGS;
        end else if (addr_load) begin
            current_addr <= addr_in;
        end else if (read_strobe) begin
            current_addr <= next_addr; // [R9]
        end
    end

    // ==========================================================
    // Read decode
    // ==========================================================
    always_comb begin
        if (current_addr == aor_pkg::ADDR_EVENT_FLAGS) begin
            sel_data = event_flags_in; // [R10]
        end else if (current_addr == aor_pkg::ADDR_TEMPERATURE) begin
            sel_data = temperature_in; // [R1]
        end else if (current_addr == aor_pkg::ADDR_MAG_LOW) begin
            sel_data = mag_low; // [R2]
        end else if (current_addr == aor_pkg::ADDR_MAG_HIGH) begin
            sel_data = mag_high; // [R2]
        end else if (current_addr == aor_pkg::ADDR_X_LOW) begin
            sel_data = x_low; // [R5]
        end else if (current_addr == aor_pkg::ADDR_X_HIGH) begin
            sel_data = x_high; // [R5]
        end else if (current_addr == aor_pkg::ADDR_Y_LOW) begin
            sel_data = y_low; // [R5]
        end else if (current_addr == aor_pkg::ADDR_Y_HIGH) begin
            sel_data = y_high; // [R5]
        end else if (current_addr == aor_pkg::ADDR_Z_LOW) begin
            sel_data = z_low; // [R5]
        end else if (current_addr == aor_pkg::ADDR_Z_HIGH) begin
            sel_data = z_high; // [R5]
        end else if (current_addr == aor_pkg::ADDR_FACTORY_ONE) begin
            sel_data = aor_pkg::FACTORY_ONE_RESET; // [R11]
        end else begin
            sel_data = aor_pkg::UNMAPPED_READ;
        end
    end

    // Data of the addressed register is captured on the read strobe.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            read_data  <= aor_pkg::READ_DATA_RESET;
            read_valid <= 1'b0;
        end else begin
            read_valid <= read_strobe && !addr_load;
            if (read_strobe && !addr_load) begin
                read_data <= sel_data;
            end
        end
    end
endmodule
`default_nettype wire

// ---- aor_pkg.sv ----
// Purpose: Constants for the motion sensor output register bank.
// Assumes: Byte-wide registers at byte addresses 0x00 to 0x0A.
// Notes:   Used by the bank and the sequencer through scoped names.
package aor_pkg;
    localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'h00;
    localparam logic [7:0] ADDR_TEMPERATURE  = 8'h01;
    localparam logic [7:0] ADDR_MAG_LOW      = 8'h02;
    localparam logic [7:0] ADDR_MAG_HIGH     = 8'h03;
    localparam logic [7:0] ADDR_X_LOW        = 8'h04;
    localparam logic [7:0] ADDR_X_HIGH       = 8'h05;
    localparam logic [7:0] ADDR_Y_LOW        = 8'h06;
    localparam logic [7:0] ADDR_Y_HIGH       = 8'h07;
    localparam logic [7:0] ADDR_Z_LOW        = 8'h08;
    localparam logic [7:0] ADDR_Z_HIGH       = 8'h09;
    localparam logic [7:0] ADDR_FACTORY_ONE  = 8'h0A;
    localparam logic [7:0] FACTORY_ONE_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ     = 8'h00;
    localparam logic [7:0] READ_DATA_RESET   = 8'h00;
    localparam int         SAMPLE_BITS       = 12;
    localparam logic [7:0] AUTOINC_STEP      = 8'h01;
    localparam logic [7:0] FAST_READ_STEP    = 8'h02;
    localparam int         SEQ_SEARCH_STEPS  = 11;
endpackage

// ---- aor_byte_split.sv ----
// Purpose: Splits one 12-bit value into its low and high register bytes.
// Assumes: Byte order select is stable while the value is read.
// Notes:   Unused high bits of the high byte read as zero.
`timescale 1ns/1ps
`default_nettype none
module aor_byte_split (
    input  wire logic [11:0] value,
    input  wire logic        byte_order_select,
    output logic      [7:0]  low_byte,
    output logic      [7:0]  high_byte
);
    always_comb begin
        if (byte_order_select) begin
            low_byte  = value[11:4]; // [R4]
            high_byte = {4'h0, value[3:0]}; // [R4]
        end else begin
            low_byte  = value[7:0]; // [R4]
            high_byte = {4'h0, value[11:8]}; // [R4]
        end
    end
endmodule
`default_nettype wire

// ---- aor_next_addr.sv ----
// Purpose: Computes the auto-increment successor of a register address.
// Assumes: Only addresses 0x00 to 0x09 take part in the output sequence.
// Notes:   Skipped registers follow the inclusion and disable settings.
`timescale 1ns/1ps
`default_nettype none
module aor_next_addr (
    input  wire logic [7:0] addr,
    input  wire logic       fast_read,
    input  wire logic       temperature_autoinc_include,
    input  wire logic       magnitude_calc_enable,
    input  wire logic       x_axis_disable,
    input  wire logic       y_axis_disable,
    input  wire logic       z_axis_disable,
    output logic      [7:0] next_addr
);
    logic [7:0] cand;
    logic       skip;
    // Walks forward up to eleven steps, stopping at the first kept address.
    always_comb begin
        next_addr = aor_pkg::ADDR_EVENT_FLAGS;
        cand      = addr;
        skip      = 1'b0;
        for (int i = 0; i < aor_pkg::SEQ_SEARCH_STEPS; i++) begin
            if (cand >= aor_pkg::ADDR_Z_HIGH) begin
                cand = aor_pkg::ADDR_EVENT_FLAGS; // [R9]
            end else if (fast_read && cand >= aor_pkg::ADDR_X_LOW) begin
                cand = cand + aor_pkg::FAST_READ_STEP; // [R12]
                if (cand > aor_pkg::ADDR_Z_LOW) begin
                    cand = aor_pkg::ADDR_EVENT_FLAGS; // [R12]
                end
            end else begin
                cand = cand + aor_pkg::AUTOINC_STEP;
            end
            skip = 1'b0;
            if (cand == aor_pkg::ADDR_TEMPERATURE) begin
                skip = !temperature_autoinc_include; // [R1]
            end else if (cand == aor_pkg::ADDR_MAG_LOW || cand == aor_pkg::ADDR_MAG_HIGH) begin
                skip = !magnitude_calc_enable; // [R3]
            end else if (cand == aor_pkg::ADDR_X_LOW || cand == aor_pkg::ADDR_X_HIGH) begin
                skip = x_axis_disable; // [R6]
            end else if (cand == aor_pkg::ADDR_Y_LOW || cand == aor_pkg::ADDR_Y_HIGH) begin
                skip = y_axis_disable; // [R7]
            end else if (cand == aor_pkg::ADDR_Z_LOW || cand == aor_pkg::ADDR_Z_HIGH) begin
                skip = z_axis_disable; // [R8]
            end
            if (fast_read && cand == aor_pkg::ADDR_MAG_HIGH) begin
                skip = 1'b1; // [R12]
            end
            if (!skip) begin
                next_addr = cand;
                break;
            end
        end
    end
endmodule
`default_nettype wire

// ---- aor_output_bank_chk.sv ----
// Purpose: Port-level assertions for the output register bank.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes:   Attached to every bank instance by bind.
`timescale 1ns/1ps
`default_nettype none
module aor_output_bank_chk (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       addr_load,
    input wire logic [7:0] addr_in,
    input wire logic       read_strobe,
    input wire logic [7:0] event_flags_in,
    input wire logic [7:0] temperature_in,
    input wire logic       fast_read,
    input wire logic       temperature_autoinc_include,
    input wire logic       magnitude_calc_enable,
    input wire logic [7:0] read_data,
    input wire logic       read_valid,
    input wire logic [7:0] current_addr
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    wire logic rd = read_strobe && !addr_load;
    wire logic rn = rd && !fast_read;
    valid_answer_a: assert property (rd |=> read_valid) else $error("read gave no valid");
    stray_valid_a: assert property (!rd |=> !read_valid) else $error("valid without read");
    load_addr_a: assert property (addr_load |=> current_addr == $past(addr_in)) else $error("load missed");
    addr_hold_a: assert property (!addr_load && !read_strobe |=> $stable(current_addr)) else $error("addr moved");
    data_hold_a: assert property (!read_valid |-> $stable(read_data)) else $error("data moved");
    flags_read_a: assert property (rd && current_addr == 8'h00 |=> read_data == $past(event_flags_in))
        else $error("flags wrong");
    temp_read_a: assert property (rd && current_addr == 8'h01 |=> read_data == $past(temperature_in))
        else $error("temperature wrong");
    factory_zero_a: assert property (rd && current_addr == 8'h0A |=> read_data == 8'h00)
        else $error("reserved not zero");
    normal_wrap_a: assert property (rn && current_addr == 8'h09 |=> current_addr == 8'h00)
        else $error("no wrap");
    temp_skip_a: assert property (
        rn && current_addr == 8'h00 && !temperature_autoinc_include |=> current_addr != 8'h01)
        else $error("temperature not skipped");
    mag_skip_a: assert property (
        rn && current_addr == 8'h01 && !magnitude_calc_enable |=> current_addr != 8'h02)
        else $error("magnitude not skipped");
    cover property (rd && fast_read);
    cover property (addr_load && read_strobe);
    cover property (rn && current_addr == 8'h09);
endmodule
bind aor_output_bank aor_output_bank_chk u_aor_output_bank_chk (.ref_clk, .reset, .addr_load, .addr_in,
    .read_strobe, .event_flags_in, .temperature_in, .fast_read, .temperature_autoinc_include,
    .magnitude_calc_enable, .read_data, .read_valid, .current_addr);
`default_nettype wire

// ---- aor_host_model.sv ----
// Purpose: Host side that loads a start address and strobes reads.
// Assumes: Requests change just after a rising edge.
// Notes:   The valid flag is sampled one cycle after the strobe edge.
`timescale 1ns/1ps
`default_nettype none
module aor_host_model (
    input  wire logic       ref_clk,
    input  wire logic       read_valid,
    output var  logic       addr_load,
    output var  logic [7:0] addr_in,
    output var  logic       read_strobe
);
    initial begin
        addr_load = 1'b0;
        addr_in = 8'h00;
        read_strobe = 1'b0;
    end
    // A read strobed together with a load is meant to be ignored.
    task automatic xfer(input logic ld, input logic rs, input logic [7:0] a, output logic v);
        @(posedge ref_clk);
        addr_load <= ld;
        addr_in <= a;
        read_strobe <= rs;
        @(posedge ref_clk);
        addr_load <= 1'b0;
        read_strobe <= 1'b0;
        #1;
        v = read_valid;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the output register bank.
// Assumes: Host model issues every load and read.
// Notes:   Expected data and addresses are rebuilt from settings here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk, reset, bo, fr, ti, me, xd, yd, zd, ld, rs, v;
    logic [7:0]  flags, temp, addr_in, read_data, current_addr, a;
    logic [11:0] norm, xs, ys, zs;
    int          n_mismatch, num_checks;
    aor_output_bank u_aor_output_bank (.ref_clk, .reset, .addr_load(ld), .addr_in, .read_strobe(rs),
        .event_flags_in(flags), .temperature_in(temp), .accel_norm_value(norm), .x_sample(xs), .y_sample(ys),
        .z_sample(zs), .byte_order_select(bo), .fast_read(fr), .temperature_autoinc_include(ti),
        .magnitude_calc_enable(me), .x_axis_disable(xd), .y_axis_disable(yd), .z_axis_disable(zd),
        .read_data, .read_valid(v), .current_addr);
    aor_host_model u_aor_host_model (.ref_clk, .read_valid(v), .addr_load(ld), .addr_in, .read_strobe(rs));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [7:0] half(input logic [11:0] s, input logic hi);
        if (hi)
            return bo ? {4'h0, s[3:0]} : {4'h0, s[11:8]};
        return bo ? s[11:4] : s[7:0];
    endfunction
    function automatic logic [7:0] exp_data(input logic [7:0] r);
        case (r)
            8'h00: return flags;
            8'h01: return temp;
            8'h02, 8'h03: return half(norm, r[0]);
            8'h04, 8'h05: return half(xs, r[0]);
            8'h06, 8'h07: return half(ys, r[0]);
            8'h08, 8'h09: return half(zs, r[0]);
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] exp_next(input logic [7:0] r);
        do
            r = (r >= 8'h09 || (fr && r >= 8'h07)) ? 8'h00 : r + ((fr && r >= 8'h04) ? 8'h02 : 8'h01);
        while (!(r == 8'h00 || (r == 8'h01 && ti) || (r[7:1] == 7'h01 && me && !(fr && r[0]))
            || (r[7:1] == 7'h02 && !xd) || (r[7:1] == 7'h03 && !yd) || (r[7:1] == 7'h04 && !zd)));
        return r;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Reads the register at the running address and judges data and successor.
    task automatic rd_chk();
        logic vv;
        u_aor_host_model.xfer(1'b0, 1'b1, 8'h00, vv);
        check({7'h00, vv}, 8'h01);
        check(read_data, exp_data(a));
        a = exp_next(a);
        check(current_addr, a);
    endtask
    task automatic run(input logic [4:0] cfg, input logic [7:0] start, input int n);
        logic vv;
        @(posedge ref_clk);
        {ti, me, xd, yd, zd} <= cfg;
        u_aor_host_model.xfer(1'b1, 1'b0, start, vv);
        a = start;
        repeat (n) rd_chk();
    endtask
    task automatic t_map();
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            {bo, flags, temp} <= {k[0], {16{k[0]}} ^ 16'h5AC3};
            {norm, xs, ys, zs} <= {48{k[0]}} ^ 48'hABC_1A3_456_789;
            run(5'b11000, 8'h00, 11);
            run(5'b11000, 8'h0A, 1);
        end
    endtask
    task automatic t_skip();
        logic [4:0] cfgs [5] = '{5'b01000, 5'b10000, 5'b11100, 5'b11010, 5'b11001};
        foreach (cfgs[c]) run(cfgs[c], 8'h00, 6);
        @(posedge ref_clk);
        fr <= 1'b1;
        run(5'b11000, 8'h04, 3);
        run(5'b11110, 8'h04, 1);
        run(5'b11000, 8'h00, 6);
        @(posedge ref_clk);
        fr <= 1'b0;
    endtask
    task automatic t_refuse();
        logic vv;
        u_aor_host_model.xfer(1'b1, 1'b1, 8'h07, vv);
        check({7'h00, vv}, 8'h00);
        check(current_addr, 8'h07);
        a = 8'h07;
        rd_chk();
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {reset, bo, fr, ti, me, xd, yd, zd} = 8'h98;
        {flags, temp, norm, xs, ys, zs} = 64'h0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        t_map();
        t_skip();
        t_refuse();
        report_and_stop();
    end
    initial begin
        #40000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
